// [hw/ufms_pkg.sv]
// Purpose: Shared constants, types and helpers of the serial port FIFO and modem status block
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes:   Receive entries carry 8 data bits and 3 per-character status bits
`default_nettype none
package ufms_pkg;
   // Register byte offsets
   localparam logic [5:0] ADDR_DATA = 6'h00;  // Read pops receive, write pushes transmit
   localparam logic [5:0] ADDR_IER  = 6'h04;
   localparam logic [5:0] ADDR_FCR  = 6'h08;  // Write FIFO control, read interrupt identity
   localparam logic [5:0] ADDR_LCR  = 6'h0C;
   localparam logic [5:0] ADDR_LSR  = 6'h10;
   localparam logic [5:0] ADDR_MSR  = 6'h14;
   localparam logic [5:0] ADDR_RXST = 6'h18;  // Per-character status, no pop
   localparam logic [5:0] ADDR_DIV  = 6'h1C;
   localparam logic [5:0] ADDR_IST  = 6'h20;
   localparam logic [5:0] ADDR_IMSK = 6'h24;
   // Interrupt enable bit positions
   localparam int IER_RXD = 0;
   localparam int IER_TXE = 1;
   localparam int IER_LSI = 2;
   localparam int IER_MSI = 3;
   // FIFO control and line control fields
   localparam int FCR_EN    = 0;
   localparam int FCR_RXRST = 1;
   localparam int FCR_TXRST = 2;
   localparam int FCR_TRIG  = 6;
   localparam int LCR_WL    = 0;
   localparam int LCR_STOP  = 2;
   localparam int LCR_PAR   = 3;
   // Sticky status bit positions
   localparam int IST_MSI  = 0;
   localparam int IST_RXD  = 1;
   localparam int IST_TOUT = 2;
   localparam int IST_TXE  = 3;
   localparam int IST_LSI  = 4;
   // Reset values
   localparam logic [3:0]  IER_RST  = 4'h0;
   localparam logic [3:0]  LCR_RST  = 4'h3;
   localparam logic [15:0] DIV_RST  = 16'h0001;
   localparam logic [4:0]  IMSK_RST = 5'h00;
   // FIFO geometry
   localparam int FIFO_AW = 4;
   localparam int RX_W    = 11;
   localparam int TX_W    = 8;
   // Timeout length in characters
   localparam logic [2:0] TOUT_CHARS = 3'h4;
   // Interrupt identity codes
   localparam logic [3:0] IIR_NONE = 4'h1;
   localparam logic [3:0] IIR_LSI  = 4'h6;
   localparam logic [3:0] IIR_RXD  = 4'h4;
   localparam logic [3:0] IIR_TOUT = 4'hC;
   localparam logic [3:0] IIR_TXE  = 4'h2;
   localparam logic [3:0] IIR_MSI  = 4'h0;
   localparam logic [1:0] IIR_FIFO = 2'h3;
   // Receive trigger levels in bytes
   localparam logic [4:0] TRIG_L0 = 5'h01;
   localparam logic [4:0] TRIG_L1 = 5'h04;
   localparam logic [4:0] TRIG_L2 = 5'h08;
   localparam logic [4:0] TRIG_L3 = 5'h0E;
   // Bus handshake states
   typedef enum logic [0:0] {
      UFMS_IDLE = 1'b0,
      UFMS_ACK  = 1'b1
   } ufms_bus_t;

   // Trigger field to byte count
   function automatic logic [4:0] ufms_trig(input logic [1:0] sel);
      logic [4:0] r;
      r = (sel == 2'h0) ? TRIG_L0 : (sel == 2'h1) ? TRIG_L1 :
          (sel == 2'h2) ? TRIG_L2 : TRIG_L3;
      return r;
   endfunction : ufms_trig

   // Bits per character: start, data, parity, stop
   function automatic logic [3:0] ufms_char_bits(input logic [3:0] lcr);
      logic [3:0] r;
      r = 4'h7 + {2'h0, lcr[LCR_WL+1:LCR_WL]} + {3'h0, lcr[LCR_PAR]}
          + {3'h0, lcr[LCR_STOP]};
      return r;
   endfunction : ufms_char_bits
endpackage : ufms_pkg
`default_nettype wire

// [hw/ufms_fifo.sv]
// Purpose: Sixteen-entry synchronous FIFO
// Assumes: Push when full and pop when empty are ignored
// Notes:   Head is read combinationally from the array
`default_nettype none
module ufms_fifo #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   arst_n,
   // Control
   input  wire logic                   clear,
   input  wire logic                   push,
   input  wire logic [W-1:0]           push_data,
   input  wire logic                   pop,
   // State
   output logic      [W-1:0]           head,
   output logic      [ufms_pkg::FIFO_AW:0] count,
   output logic                        full,
   output logic                        empty
);
   import ufms_pkg::*;
   logic [W-1:0]       mem [0:(1<<FIFO_AW)-1];
   logic [FIFO_AW-1:0] wr_ptr_reg;
   logic [FIFO_AW-1:0] rd_ptr_reg;
   logic [FIFO_AW:0]   count_reg;
   logic               do_push;
   logic               do_pop;

   // Accepted operations
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign full    = count_reg[FIFO_AW];
   assign empty   = (count_reg == '0);
   assign count   = count_reg;
   assign head    = mem[rd_ptr_reg];

   // Storage, no reset needed
   always_ff @(posedge sys_clk) begin
      if (do_push) mem[wr_ptr_reg] <= push_data;
   end

   // Pointers and fill count
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (clear) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + FIFO_AW'(do_push);
         rd_ptr_reg <= rd_ptr_reg + FIFO_AW'(do_pop);
         count_reg  <= count_reg + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop);
      end
   end
endmodule : ufms_fifo
`default_nettype wire

// [hw/ufms_timeout.sv]
// Purpose: Bit-time counter for the receive character timeout
// Assumes: bit_tick pulses once per bit time
// Notes:   Saturates at the limit so expiry stays a level
`default_nettype none
module ufms_timeout (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   // Control
   input  wire logic       bit_tick,
   input  wire logic       restart,
   input  wire logic [5:0] limit,
   // Status
   output logic            expired
);
   import ufms_pkg::*;
   logic [5:0] cnt_reg;

   assign expired = (cnt_reg >= limit);

   // Count bit times since the last restart
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 6'h00;
      end else if (restart) begin
         cnt_reg <= 6'h00;
      end else if (bit_tick && !expired) begin
         cnt_reg <= cnt_reg + 6'h01;
      end
   end
endmodule : ufms_timeout
`default_nettype wire

// [hw/ufms_uart.sv]
// Purpose: Serial port FIFO interrupts, polling, receive pointer and modem status change logic
// Assumes: Receive and transmit shifters outside; inputs synchronous to sys_clk
// Notes:   Avalon-MM slave answers on the second edge of every request
//
// Added by the designer: the address map and the Avalon-MM register port.
`default_nettype none
module ufms_uart (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Received characters
   input  wire logic        rx_char_valid,
   input  wire logic [7:0]  rx_char_data,
   input  wire logic [2:0]  rx_char_status,
   // Characters to transmit
   output logic             tx_char_valid,
   output logic      [7:0]  tx_char_data,
   input  wire logic        tx_char_ready,
   // Modem control inputs, active low
   input  wire logic        clear_send_n_in,
   input  wire logic        set_ready_n_in,
   input  wire logic        ring_n_in,
   input  wire logic        carrier_detect_in_n,
   // Interrupts
   output logic             uart_irq,
   output logic             sticky_irq
);
   import ufms_pkg::*;

   ufms_bus_t   state_reg;
   logic        wait_reg;
   logic [31:0] rdata_reg;
   logic [3:0]  ier_reg;
   logic [3:0]  lcr_reg;
   logic [15:0] div_reg;
   logic [15:0] div_cnt_reg;
   logic        fifo_enable_bit;
   logic [1:0]  rx_trigger_level;
   logic [1:0]  rx_trig_reg;
   logic [3:0]  delta_reg;
   logic [3:0]  mst_q_reg;
   logic        primed_reg;
   logic        tout_pend_reg;
   logic        txe_pend_reg;
   logic        tx_empty_q_reg;
   logic        overrun_reg;
   logic [4:0]  src_q_reg;
   logic [4:0]  ist_reg;
   logic [4:0]  imsk_reg;
   logic        irq_reg;
   logic        sirq_reg;
   logic        txv_reg;
   logic [7:0]  txd_reg;

   // Bus decode
   logic        acc;
   logic        rd_acc;
   logic        wr_acc;
   logic        wr_b0;
   assign acc    = (avs_read || avs_write) && (state_reg == UFMS_ACK);
   assign rd_acc = acc && avs_read;
   assign wr_acc = acc && avs_write;
   assign wr_b0  = wr_acc && avs_byteenable[0];
   logic        sel_data;
   logic        sel_fcr;
   logic        sel_msr;
   logic        sel_lsr;
   logic        sel_ist;
   logic        sel_rxst;
   assign sel_data = (avs_address == ADDR_DATA);
   assign sel_fcr  = (avs_address == ADDR_FCR);
   assign sel_msr  = (avs_address == ADDR_MSR);
   assign sel_lsr  = (avs_address == ADDR_LSR);
   assign sel_ist  = (avs_address == ADDR_IST);
   assign sel_rxst = (avs_address == ADDR_RXST);

   // FIFO control write effects
   logic        fcr_wr;
   logic        en_new;
   logic        rx_clear;
   logic        tx_clear;
   assign fcr_wr   = wr_b0 && sel_fcr;
   assign en_new   = avs_writedata[FCR_EN];
   assign rx_clear = fcr_wr && ((en_new != fifo_enable_bit) ||
                                (en_new && avs_writedata[FCR_RXRST]));
   assign tx_clear = fcr_wr && ((en_new != fifo_enable_bit) ||
                                (en_new && avs_writedata[FCR_TXRST]));

   // Receive FIFO
   logic [RX_W-1:0]  rx_head;
   logic [FIFO_AW:0] rx_count;
   logic             rx_full;
   logic             rx_empty;
   logic             rx_pop;
   assign rx_pop = rd_acc && sel_data && !rx_empty;
   ufms_fifo #(.W(RX_W)) u_rx_fifo (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .clear     (rx_clear),
      .push      (rx_char_valid),
      .push_data ({rx_char_status, rx_char_data}),
      .pop       (rx_pop),
      .head      (rx_head),
      .count     (rx_count),
      .full      (rx_full),
      .empty     (rx_empty)
   );

   // Transmit FIFO
   logic [TX_W-1:0]  tx_head;
   logic             tx_full;
   logic             tx_empty;
   logic             tx_push;
   logic             tx_load;
   assign tx_push = wr_b0 && sel_data;
   assign tx_load = (!txv_reg || tx_char_ready) && !tx_empty;
   ufms_fifo #(.W(TX_W)) u_tx_fifo (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .clear     (tx_clear),
      .push      (tx_push),
      .push_data (avs_writedata[7:0]),
      .pop       (tx_load),
      .head      (tx_head),
      .count     (),
      .full      (tx_full),
      .empty     (tx_empty)
   );

   // Baud tick and character timeout
   logic        bit_tick;
   logic [5:0]  tout_limit;
   logic        tout_exp;
   assign bit_tick   = (div_cnt_reg + 16'h0001 >= div_reg);
   assign tout_limit = 6'(TOUT_CHARS) * {2'h0, ufms_char_bits(lcr_reg)};
   ufms_timeout u_timeout (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .bit_tick (bit_tick),
      .restart  (rx_char_valid || rx_pop || rx_clear),
      .limit    (tout_limit),
      .expired  (tout_exp)
   );

   // Modem status change detection
   logic [3:0]  mst;
   logic [3:0]  delta_set;
   logic        msr_clr;
   assign mst = ~{carrier_detect_in_n, ring_n_in, set_ready_n_in, clear_send_n_in};
   assign delta_set[3] = primed_reg && (mst[3] != mst_q_reg[3]);
   assign delta_set[2] = primed_reg && mst_q_reg[2] && !mst[2];
   assign delta_set[1] = primed_reg && (mst[1] != mst_q_reg[1]);
   assign delta_set[0] = primed_reg && (mst[0] != mst_q_reg[0]);
   assign msr_clr = rd_acc && sel_msr;

   // Interrupt sources, each behind an enable; timeout shares the receive data enable
   logic [4:0]  trig;
   logic        rx_trig;
   logic [4:0]  src;
   assign rx_trigger_level = rx_trig_reg;
   assign trig    = fifo_enable_bit ? ufms_trig(rx_trigger_level) : TRIG_L0;
   assign rx_trig = (rx_count >= {1'b0, trig});
   assign src[IST_MSI]  = ier_reg[IER_MSI] && (delta_reg != 4'h0);
   assign src[IST_RXD]  = ier_reg[IER_RXD] && rx_trig;
   assign src[IST_TOUT] = ier_reg[IER_RXD] && tout_pend_reg;
   assign src[IST_TXE]  = ier_reg[IER_TXE] && txe_pend_reg;
   assign src[IST_LSI]  = ier_reg[IER_LSI] && overrun_reg;
   logic [3:0]  iir;
   assign iir = src[IST_LSI] ? IIR_LSI : src[IST_RXD] ? IIR_RXD :
                src[IST_TOUT] ? IIR_TOUT : src[IST_TXE] ? IIR_TXE :
                src[IST_MSI] ? IIR_MSI : IIR_NONE;

   // Read data selection, unmapped reads zero
   logic [7:0]  lsr;
   logic [31:0] rd_mux;
   assign lsr = {1'b0, tx_empty && !txv_reg, tx_empty, 3'h0, overrun_reg, !rx_empty};
   assign rd_mux =
      (avs_address == ADDR_DATA) ? {24'h0, rx_head[7:0]} :
      (avs_address == ADDR_IER)  ? {28'h0, ier_reg} :
      (avs_address == ADDR_FCR)  ? {24'h0, fifo_enable_bit ? IIR_FIFO : 2'h0, 2'h0, iir} :
      (avs_address == ADDR_LCR)  ? {28'h0, lcr_reg} :
      (avs_address == ADDR_LSR)  ? {24'h0, lsr} :
      (avs_address == ADDR_MSR)  ? {24'h0, mst, delta_reg} :
      (avs_address == ADDR_RXST) ? {29'h0, rx_head[RX_W-1:8]} :
      (avs_address == ADDR_DIV)  ? {16'h0, div_reg} :
      (avs_address == ADDR_IST)  ? {27'h0, ist_reg} :
      (avs_address == ADDR_IMSK) ? {27'h0, imsk_reg} : 32'h0000_0000;

   // Bus handshake: one wait cycle, then accept
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= UFMS_IDLE;
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         unique case (state_reg)
            UFMS_IDLE: begin
               if (avs_read || avs_write) begin
                  state_reg <= UFMS_ACK;
                  wait_reg  <= 1'b0;
                  rdata_reg <= avs_read ? rd_mux : 32'h0000_0000;
               end
            end
            UFMS_ACK: begin
               state_reg <= UFMS_IDLE;
               wait_reg  <= 1'b1;
            end
         endcase
      end
   end

   // Software-written configuration
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ier_reg         <= IER_RST;
         lcr_reg         <= LCR_RST;
         div_reg         <= DIV_RST;
         imsk_reg        <= IMSK_RST;
         fifo_enable_bit <= 1'b0;
         rx_trig_reg     <= 2'h0;
      end else begin
         if (wr_b0 && avs_address == ADDR_IER) ier_reg <= avs_writedata[3:0];
         if (wr_b0 && avs_address == ADDR_LCR) lcr_reg <= avs_writedata[3:0];
         if (wr_b0 && avs_address == ADDR_IMSK) imsk_reg <= avs_writedata[4:0];
         if (wr_b0 && avs_address == ADDR_DIV) div_reg[7:0] <= avs_writedata[7:0];
         if (wr_acc && avs_byteenable[1] && avs_address == ADDR_DIV) begin
            div_reg[15:8] <= avs_writedata[15:8];
         end
         if (fcr_wr) begin
            fifo_enable_bit <= en_new;
            rx_trig_reg     <= avs_writedata[FCR_TRIG+1:FCR_TRIG];
         end
      end
   end

   // Baud divider
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) div_cnt_reg <= 16'h0000;
      else div_cnt_reg <= bit_tick ? 16'h0000 : div_cnt_reg + 16'h0001;
   end

   // Modem change bits, set wins over read clear
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mst_q_reg  <= 4'h0;
         primed_reg <= 1'b0;
         delta_reg  <= 4'h0;
      end else begin
         mst_q_reg  <= mst;
         primed_reg <= 1'b1;
         delta_reg  <= (msr_clr ? 4'h0 : delta_reg) | delta_set;
      end
   end

   // Pending timeout, transmit empty and overrun
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tout_pend_reg  <= 1'b0;
         txe_pend_reg   <= 1'b0;
         tx_empty_q_reg <= 1'b0;
         overrun_reg    <= 1'b0;
      end else begin
         tout_pend_reg  <= !rx_pop && !rx_clear && (tout_pend_reg ||
                           (fifo_enable_bit && tout_exp && !rx_empty));
         tx_empty_q_reg <= tx_empty;
         txe_pend_reg   <= (tx_empty && !tx_empty_q_reg) ||
                           (txe_pend_reg && !tx_push);
         overrun_reg    <= (rx_char_valid && rx_full) ||
                           (overrun_reg && !(rd_acc && sel_lsr));
      end
   end

   // Sticky status, read clears, new events win
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         src_q_reg <= 5'h00;
         ist_reg   <= 5'h00;
         irq_reg   <= 1'b0;
         sirq_reg  <= 1'b0;
      end else begin
         src_q_reg <= src;
         ist_reg   <= ((rd_acc && sel_ist) ? 5'h00 : ist_reg) | (src & ~src_q_reg);
         irq_reg   <= (src != 5'h00);
         sirq_reg  <= ((ist_reg & imsk_reg) != 5'h00);
      end
   end

   // Transmit output stage
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         txv_reg <= 1'b0;
         txd_reg <= 8'h00;
      end else if (tx_load) begin
         txv_reg <= 1'b1;
         txd_reg <= tx_head;
      end else if (tx_char_ready) begin
         txv_reg <= 1'b0;
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign tx_char_valid   = txv_reg;
   assign tx_char_data    = txd_reg;
   assign uart_irq        = irq_reg;
   assign sticky_irq      = sirq_reg;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   msr_clear_a: assert property ((msr_clr && delta_set == 4'h0) |=> delta_reg == 4'h0)
      else $error("modem change bits not cleared by read");
   cts_delta_a: assert property ((primed_reg && mst[0] != mst_q_reg[0]) |=> delta_reg[0])
      else $error("clear to send change missed");
   dsr_delta_a: assert property ((primed_reg && $changed(mst[1])) |-> ##1 delta_reg[1])
      else $error("data set ready change missed");
   dcd_delta_a: assert property ($rose(delta_reg[3]) |-> $past(mst[3]) != $past(mst_q_reg[3]))
      else $error("carrier change bit set without change");
   ring_edge_a: assert property ($rose(delta_reg[2]) |-> $past(mst_q_reg[2]) && !$past(mst[2]))
      else $error("ring bit set without trailing edge");
   msi_irq_a: assert property ((delta_reg != 4'h0 && ier_reg[IER_MSI]) |=> uart_irq)
      else $error("modem status interrupt missing");
   rx_trig_a: assert property ((ier_reg[IER_RXD] && rx_count >= {1'b0, trig}) |=> uart_irq)
      else $error("receive trigger interrupt missing");
   poll_quiet_a: assert property ((ier_reg == 4'h0) |=> !uart_irq)
      else $error("interrupt in polling mode");
   pop_ptr_a: assert property ((rd_acc && sel_rxst && !rx_char_valid) |=> $stable(rx_count))
      else $error("status read moved receive pointer");
   tout_clear_a: assert property (rx_pop |=> !tout_pend_reg)
      else $error("timeout not cleared by data read");
   tout_set_a: assert property ($rose(tout_pend_reg) |-> $past(tout_exp && !rx_empty))
      else $error("timeout without cause");
   txe_clear_a: assert property ((tx_push && !tx_full && !(tx_empty && !tx_empty_q_reg))
      |=> !txe_pend_reg)
      else $error("transmit empty not cleared by write");
   modem_change_c: cover property (msr_clr ##1 delta_set != 4'h0);
   timeout_c:      cover property ($rose(tout_pend_reg) ##[1:50] rx_pop);
   trigger_c:      cover property (rx_trig && fifo_enable_bit && rx_trig_reg == 2'h3);
endmodule : ufms_uart
`default_nettype wire

// [tb/ufms_modem_model.sv]
// Purpose: Modem side model: control lines, received and accepted characters
// Assumes: Bench calls its tasks right after a rising clock edge
// Notes:   Idle receive data shows the inverse of the last byte sent
`default_nettype none
module ufms_modem_model (
   // Clock
   input  wire logic       sys_clk,
   // Modem control lines, active low: cts, dsr, ring, carrier
   output logic      [3:0] lines_n,
   // Received characters
   output logic            rx_char_valid,
   output logic      [7:0] rx_char_data,
   output logic      [2:0] rx_char_status,
   // Characters from the port
   input  wire logic       tx_char_valid,
   input  wire logic [7:0] tx_char_data,
   output logic            tx_char_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       stall;
   logic [7:0] last_tx;
   int         tx_count;
   // Lines idle high, nothing sent yet
   initial begin
      lines_n = 4'hF;
      rx_char_valid = 1'b0;
      rx_char_data = 8'h00;
      rx_char_status = 3'h0;
      stall = 1'b0;
      tx_count = 0;
   end
   assign tx_char_ready = !stall;
   // Line and stall changes, called just after a clock edge
   task set_lines(input logic [3:0] v);
      lines_n <= v;
   endtask : set_lines
   task set_stall(input logic v);
      stall <= v;
   endtask : set_stall
   // Take each character offered while not stalling
   always @(posedge sys_clk) begin
      if (tx_char_valid && tx_char_ready) begin
         last_tx <= tx_char_data;
         tx_count <= tx_count + 1;
      end
   end
   // One-cycle character pulse, then scrambled idle data
   task send(input logic [7:0] d, input logic [2:0] s);
      @(posedge sys_clk);
      rx_char_valid <= 1'b1;
      rx_char_data <= d;
      rx_char_status <= s;
      @(posedge sys_clk);
      rx_char_valid <= 1'b0;
      rx_char_data <= ~d;
      rx_char_status <= ~s;
   endtask : send
endmodule : ufms_modem_model
`default_nettype wire

// [tb/uart_fifo_modem_status_tb.sv]
// Purpose: Self-checking bench of the FIFO interrupt and modem status block
// Assumes: One wait cycle per bus request, divisor 1, 8N1 characters
// Notes:   Trigger cases run from a table; modem, timeout, transmit by hand
`default_nettype none
module uart_fifo_modem_status_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ufms_pkg::*;
   typedef struct packed {
      logic [1:0] trig;
      logic [3:0] ier;
      logic [4:0] n;
      logic       irq;
   } ufms_row_t;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        rx_char_valid;
   logic [7:0]  rx_char_data;
   logic [2:0]  rx_char_status;
   logic        tx_char_valid;
   logic [7:0]  tx_char_data;
   logic        tx_char_ready;
   logic [3:0]  lines_n;
   logic        uart_irq;
   logic        sticky_irq;
   logic [31:0] q;
   int          fails = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   ufms_row_t   rows [8] = '{'{2'h0, 4'h1, 5'h01, 1'h1}, '{2'h1, 4'h1, 5'h03, 1'h0},
      '{2'h1, 4'h1, 5'h04, 1'h1}, '{2'h2, 4'h1, 5'h07, 1'h0}, '{2'h2, 4'h1, 5'h08, 1'h1},
      '{2'h3, 4'h1, 5'h0D, 1'h0}, '{2'h3, 4'h1, 5'h0E, 1'h1}, '{2'h3, 4'h0, 5'h0E, 1'h0}};
   always #2 sys_clk = ~sys_clk;
   ufms_uart dut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
      .rx_char_status(rx_char_status), .tx_char_valid(tx_char_valid),
      .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
      .clear_send_n_in(lines_n[0]), .set_ready_n_in(lines_n[1]), .ring_n_in(lines_n[2]),
      .carrier_detect_in_n(lines_n[3]), .uart_irq(uart_irq), .sticky_irq(sticky_irq));
   ufms_modem_model mdm (.sys_clk(sys_clk), .lines_n(lines_n), .rx_char_valid(rx_char_valid),
      .rx_char_data(rx_char_data), .rx_char_status(rx_char_status),
      .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
      .tx_char_ready(tx_char_ready));
   // Compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One bus request, held until waitrequest is sampled low
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task give_verdict();
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      bus(1'b0, ADDR_MSR, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, ADDR_IER, 32'h8);
      bus(1'b1, ADDR_IMSK, 32'h1);
      mdm.set_lines(4'hE);
      repeat (4) @(posedge sys_clk);
      chk({30'h0, uart_irq, sticky_irq}, 32'h3);
      bus(1'b0, ADDR_MSR, 32'h0);
      chk(q, 32'h11);
      bus(1'b0, ADDR_MSR, 32'h0);
      chk(q, 32'h10);
      bus(1'b0, ADDR_IST, 32'h0);
      chk(q, 32'h1);
      bus(1'b1, ADDR_IMSK, 32'h0);
      mdm.set_lines(4'h0);
      repeat (4) @(posedge sys_clk);
      chk({30'h0, uart_irq, sticky_irq}, 32'h2);
      bus(1'b0, ADDR_MSR, 32'h0);
      chk(q, 32'hFA);
      mdm.set_lines(4'h4);
      repeat (4) @(posedge sys_clk);
      bus(1'b0, ADDR_MSR, 32'h0);
      chk(q, 32'hB4);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, ADDR_FCR, {24'h0, rows[i].trig, 6'h07});
         bus(1'b1, ADDR_IER, {28'h0, rows[i].ier});
         for (int k = 0; k < rows[i].n; k++) mdm.send(8'(k), 3'h0);
         repeat (4) @(posedge sys_clk);
         chk({31'h0, uart_irq}, {31'h0, rows[i].irq});
         if (rows[i].irq) begin
            bus(1'b0, ADDR_DATA, 32'h0);
            repeat (3) @(posedge sys_clk);
            chk({31'h0, uart_irq}, 32'h0);
         end
      end
      bus(1'b0, ADDR_LSR, 32'h0);
      chk({31'h0, q[0]}, 32'h1);
      bus(1'b1, ADDR_FCR, 32'hC7);
      bus(1'b1, ADDR_IER, 32'h1);
      mdm.send(8'h3C, 3'h5);
      repeat (39) @(posedge sys_clk);
      chk({31'h0, uart_irq}, 32'h0);
      repeat (5) @(posedge sys_clk);
      chk({31'h0, uart_irq}, 32'h1);
      bus(1'b0, ADDR_FCR, 32'h0);
      chk(q, 32'hCC);
      bus(1'b0, ADDR_RXST, 32'h0);
      chk(q, 32'h5);
      bus(1'b0, ADDR_DATA, 32'h0);
      chk(q, 32'h3C);
      repeat (3) @(posedge sys_clk);
      chk({31'h0, uart_irq}, 32'h0);
      bus(1'b1, ADDR_IER, 32'h2);
      mdm.set_stall(1'b1);
      bus(1'b1, ADDR_DATA, 32'hA5);
      bus(1'b1, ADDR_DATA, 32'h5A);
      repeat (4) @(posedge sys_clk);
      chk({22'h0, uart_irq, tx_char_valid, tx_char_data}, 32'h1A5);
      mdm.set_stall(1'b0);
      repeat (10) @(posedge sys_clk);
      chk({22'h0, uart_irq, 1'b0, mdm.last_tx}, 32'h25A);
      chk(32'(mdm.tx_count), 32'h2);
      // Mid-run reset: outputs quiet, change bits and enables back to rest
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({avs_readdata[27:0], avs_waitrequest, uart_irq, sticky_irq, tx_char_valid}, 32'h8);
      arst_n <= 1'b1;
      bus(1'b0, ADDR_MSR, 32'h0);
      chk(q, 32'hB0);
      bus(1'b0, ADDR_IER, 32'h0);
      chk({q[30:0], uart_irq}, 32'h0);
      give_verdict();
   end
endmodule : uart_fifo_modem_status_tb
`default_nettype wire
